// ### common/src_pkg.sv
/*
 * Shared constants and carrier types for the system reset controller:
 * register offsets and fields, reset values, reset type codes, timing
 * counts, state encoding and the state structs of both design modules.
 * Assumes a single slow clock and a plain register port.
 */
package src_pkg;

    // Register offsets
    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_STAT       = 8'h04;
    localparam logic [7:0]  OFF_MODE       = 8'h08;

    // Control word fields
    localparam int          CTRL_PROC_BIT  = 0;
    localparam int          CTRL_PERI_BIT  = 2;
    localparam int          CTRL_EXT_BIT   = 3;
    localparam int          CTRL_KEY_LSB   = 24;
    // Write key, value arbitrary
    localparam logic [7:0]  CTRL_KEY       = 8'h5a;

    // Status word fields
    localparam int          STAT_SEEN_BIT  = 0;
    localparam int          STAT_BUSY_BIT  = 1;
    localparam int          STAT_TYPE_LSB  = 8;
    localparam int          STAT_LEVEL_BIT = 16;

    // Mode word fields
    localparam int          MODE_UEN_BIT   = 0;
    localparam int          MODE_IEN_BIT   = 4;
    localparam int          MODE_LEN_LSB   = 8;

    // Last reset type codes
    localparam logic [2:0]  RT_GENERAL     = 3'h0;
    localparam logic [2:0]  RT_WAKE        = 3'h1;
    localparam logic [2:0]  RT_WDT         = 3'h2;
    localparam logic [2:0]  RT_SW          = 3'h3;
    localparam logic [2:0]  RT_USER        = 3'h4;

    // Timing counts in slow clock cycles
    localparam logic [15:0] STARTUP_LAST   = 16'h07ff;
    localparam logic [15:0] HOLD_LAST      = 16'h0002;
    localparam int          BOOT_DLY       = 3;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } src_bus_req_t;

    typedef struct packed {
        logic proc_rst_n;
        logic periph_rst_n;
        logic backup_rst_n;
    } src_resets_t;

    typedef struct packed {
        logic       user_reset_irq_enable;
        logic       user_reset_enable;
        logic [3:0] ext_pulse_length;
    } src_mode_t;

    localparam src_mode_t MODE_RST = '{
        user_reset_irq_enable: 1'b0,
        user_reset_enable:     1'b1,
        ext_pulse_length:      4'h0
    };

    typedef enum logic [2:0] {
        ST_STARTUP  = 3'b000,
        ST_HOLD     = 3'b001,
        ST_RUN      = 3'b011,
        ST_SW       = 3'b010,
        ST_WDT      = 3'b110,
        ST_USER     = 3'b111,
        ST_CORE_OFF = 3'b101
    } src_fsm_t;

    typedef struct packed {
        src_fsm_t               st;
        logic [15:0]            cnt;
        logic [2:0]             pend;
        logic                   sw_proc;
        logic [2:0]             last_reset_type;
        logic [1:0]             pin_sync;
        logic                   pin_prev;
        logic [1:0]             drv_hist;
        logic                   user_reset_seen;
        logic                   irq;
        src_mode_t              mode;
        logic                   por_prev;
        logic [BOOT_DLY-1:0]    boot_dly;
        logic                   boot_sel;
        logic                   clk_en;
        src_resets_t            res;
        logic [31:0]            rdata;
    } src_state_t;

    typedef struct packed {
        logic [16:0] cnt;
        logic        drive;
    } src_pulse_t;

endpackage : src_pkg

// ### core/src_ext_pulse.sv
/*
 * External reset pulse shaper: drives the open-drain pin low for
 * 2^(len+1) cycles after a start, or for as long as force is high.
 * Assumes start and force come from the reset state manager.
 */
`timescale 1ns/1ns
module src_ext_pulse (
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       force_i,
    input  wire logic       start_i,
    input  wire logic [3:0] len_i,
    output logic            drive_o
);
    import src_pkg::*;

    src_pulse_t s_r;
    src_pulse_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (start_i) begin
            s_nxt.cnt   = 17'h00001 << (5'(len_i) + 5'h01);
            s_nxt.drive = 1'b1;
        end else if (s_r.cnt > 17'h00001) begin
            s_nxt.cnt   = s_r.cnt - 17'h00001;
            s_nxt.drive = 1'b1;
        end else begin
            s_nxt.cnt   = 17'h00000;
            s_nxt.drive = force_i;
        end
        if (force_i) begin
            s_nxt.drive = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_r <= '{cnt: 17'h00000, drive: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign drive_o = s_r.drive;

    // Helper: length of the last unforced pulse
    logic [17:0] hc_r;
    logic [3:0]  hlen_r;
    logic        hclean_r;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            hc_r     <= 18'h00000;
            hlen_r   <= 4'h0;
            hclean_r <= 1'b0;
        end else if (start_i) begin
            hc_r     <= 18'h00000;
            hlen_r   <= len_i;
            hclean_r <= !force_i;
        end else begin
            hc_r     <= drive_o ? hc_r + 18'h00001 : hc_r;
            hclean_r <= hclean_r && !force_i;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_quiet2;
        (!start_i && !force_i)[*2];
    endsequence

    a_pulse_two: assert property (
        (start_i && len_i == 4'h0 && !force_i) ##1 s_quiet2
        |=> !drive_o && $past(drive_o) && $past(drive_o, 2))
        else $error("Zero-length pulse is not two cycles");

    a_pulse_length: assert property (
        $fell(drive_o) && hclean_r && !$past(start_i)
        |-> hc_r == (18'h00001 << (5'(hlen_r) + 5'h01)))
        else $error("External pulse length differs from 2^(len+1)");

endmodule : src_ext_pulse

// ### core/src_core.sv
/*
 * System reset controller core on the slow clock: supply detector
 * sequencing, external pin handling, reset state manager, register port,
 * boot select capture.
 * Assumes all inputs synchronous to core_clk_i except ext_pin_i, and a
 * register master that never issues read and write together.
 */
`timescale 1ns/1ns
module src_core (
    input  wire logic                 core_clk_i,
    input  wire logic                 reset_i,
    input  wire src_pkg::src_bus_req_t bus_i,
    output logic [31:0]               rdata_o,
    input  wire logic                 backup_por_i,
    input  wire logic                 core_por_i,
    input  wire logic                 ext_pin_i,
    input  wire logic                 wdt_fault_i,
    input  wire logic                 wdt_proc_only_i,
    input  wire logic                 boot_select_pin_i,
    output src_pkg::src_resets_t      resets_o,
    output logic                      ext_pin_o,
    output logic                      ext_pin_oe_o,
    output logic                      proc_clk_en_o,
    output logic                      boot_sel_o,
    output logic                      user_irq_o
);
    import src_pkg::*;

    localparam src_state_t S_RST = '{
        st:       ST_STARTUP,
        mode:     MODE_RST,
        pin_sync: 2'b11,
        pin_prev: 1'b1,
        default:  '0
    };

    src_state_t s_r;
    src_state_t s_nxt;
    logic       ext_start;
    logic       ext_force;
    logic       stat_rd;
    logic       ctrl_ok;
    logic       user_trig;
    logic       pin_level;
    logic       pin_fall;

    assign pin_level = s_r.pin_sync[1];
    assign pin_fall  = s_r.pin_prev && !pin_level;
    assign stat_rd   = bus_i.rd && bus_i.addr == OFF_STAT;
    assign ctrl_ok   = bus_i.wr && bus_i.addr == OFF_CTRL && s_r.st == ST_RUN
                       && bus_i.wdata[CTRL_KEY_LSB +: 8] == CTRL_KEY
                       && (bus_i.wdata[CTRL_PROC_BIT] || bus_i.wdata[CTRL_PERI_BIT]
                           || bus_i.wdata[CTRL_EXT_BIT]);
    // Own pulse and its echo through the synchroniser are not a user reset
    assign user_trig = s_r.st == ST_RUN && !pin_level
                       && s_r.mode.user_reset_enable
                       && !s_r.mode.user_reset_irq_enable
                       && !ext_pin_oe_o && s_r.drv_hist == 2'b00;

    always_comb begin
        s_nxt = s_r;
        ext_start = 1'b0;
        ext_force = 1'b0;

        s_nxt.pin_sync = {s_r.pin_sync[0], ext_pin_i};
        s_nxt.pin_prev = pin_level;
        s_nxt.drv_hist = {s_r.drv_hist[0], ext_pin_oe_o};

        s_nxt.por_prev = core_por_i;
        s_nxt.boot_dly = {s_r.boot_dly[BOOT_DLY-2:0], core_por_i && !s_r.por_prev};
        if (s_r.boot_dly[BOOT_DLY-1]) begin
            s_nxt.boot_sel = boot_select_pin_i;
        end

        // Set wins over the read clear
        if (stat_rd) begin
            s_nxt.user_reset_seen = 1'b0;
        end
        if (pin_fall) begin
            s_nxt.user_reset_seen = 1'b1;
        end
        s_nxt.irq = s_nxt.user_reset_seen && s_r.mode.user_reset_irq_enable;

        if (bus_i.wr && bus_i.addr == OFF_MODE) begin
            s_nxt.mode.user_reset_enable     = bus_i.wdata[MODE_UEN_BIT];
            s_nxt.mode.user_reset_irq_enable = bus_i.wdata[MODE_IEN_BIT];
            s_nxt.mode.ext_pulse_length      = bus_i.wdata[MODE_LEN_LSB +: 4];
        end

        s_nxt.rdata = 32'h00000000;
        if (stat_rd) begin
            s_nxt.rdata[STAT_SEEN_BIT]       = s_r.user_reset_seen;
            s_nxt.rdata[STAT_BUSY_BIT]       = s_r.st == ST_SW;
            s_nxt.rdata[STAT_TYPE_LSB +: 3]  = s_r.last_reset_type;
            s_nxt.rdata[STAT_LEVEL_BIT]      = pin_level;
        end else if (bus_i.rd && bus_i.addr == OFF_MODE) begin
            s_nxt.rdata[MODE_UEN_BIT]        = s_r.mode.user_reset_enable;
            s_nxt.rdata[MODE_IEN_BIT]        = s_r.mode.user_reset_irq_enable;
            s_nxt.rdata[MODE_LEN_LSB +: 4]   = s_r.mode.ext_pulse_length;
        end

        case (s_r.st)
            ST_STARTUP: begin
                ext_force = 1'b1;
                s_nxt.res = '{default: 1'b0};
                s_nxt.clk_en = 1'b0;
                if (s_r.cnt == STARTUP_LAST) begin
                    s_nxt.st     = ST_HOLD;
                    s_nxt.cnt    = HOLD_LAST;
                    s_nxt.pend   = RT_GENERAL;
                    s_nxt.clk_en = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt + 16'h0001;
                end
            end
            ST_HOLD: begin
                ext_force = s_r.pend != RT_USER;
                s_nxt.clk_en = 1'b1;
                if (s_r.cnt == 16'h0000) begin
                    s_nxt.st = ST_RUN;
                    s_nxt.res = '{default: 1'b1};
                    s_nxt.last_reset_type = s_r.pend;
                    ext_start = s_r.pend != RT_USER;
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
            end
            ST_RUN, ST_SW: begin
                if (wdt_fault_i) begin
                    s_nxt.st = ST_WDT;
                    s_nxt.cnt = HOLD_LAST;
                    s_nxt.res.proc_rst_n = 1'b0;
                    s_nxt.res.periph_rst_n = wdt_proc_only_i;
                    ext_start = !wdt_proc_only_i;
                end else if (s_r.st == ST_SW) begin
                    if (s_r.cnt == 16'h0000) begin
                        s_nxt.st = ST_RUN;
                        s_nxt.res.proc_rst_n = 1'b1;
                        s_nxt.res.periph_rst_n = 1'b1;
                        if (s_r.sw_proc) begin
                            s_nxt.last_reset_type = RT_SW;
                        end
                    end else begin
                        s_nxt.cnt = s_r.cnt - 16'h0001;
                    end
                end else if (ctrl_ok) begin
                    s_nxt.st = ST_SW;
                    s_nxt.cnt = HOLD_LAST;
                    s_nxt.sw_proc = bus_i.wdata[CTRL_PROC_BIT];
                    s_nxt.res.proc_rst_n = !bus_i.wdata[CTRL_PROC_BIT];
                    s_nxt.res.periph_rst_n = !bus_i.wdata[CTRL_PERI_BIT];
                    ext_start = bus_i.wdata[CTRL_EXT_BIT];
                end else if (user_trig) begin
                    s_nxt.st = ST_USER;
                    s_nxt.clk_en = 1'b0;
                    s_nxt.res.proc_rst_n = 1'b0;
                    s_nxt.res.periph_rst_n = 1'b0;
                    ext_start = 1'b1;
                end
            end
            ST_WDT: begin
                if (s_r.cnt == 16'h0000) begin
                    s_nxt.st = ST_RUN;
                    s_nxt.res.proc_rst_n = 1'b1;
                    s_nxt.res.periph_rst_n = 1'b1;
                    s_nxt.last_reset_type = RT_WDT;
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
            end
            ST_USER: begin
                // Held while anyone pulls the pin, however long
                if (pin_level && !ext_pin_oe_o) begin
                    s_nxt.st = ST_HOLD;
                    s_nxt.cnt = HOLD_LAST;
                    s_nxt.pend = RT_USER;
                    s_nxt.clk_en = 1'b1;
                end
            end
            ST_CORE_OFF: begin
                ext_force = 1'b1;
                s_nxt.clk_en = 1'b0;
                if (core_por_i) begin
                    s_nxt.st = ST_HOLD;
                    s_nxt.cnt = HOLD_LAST;
                    s_nxt.pend = RT_WAKE;
                    s_nxt.clk_en = 1'b1;
                end
            end
            default: begin
                s_nxt.st = ST_STARTUP;
                s_nxt.cnt = 16'h0000;
            end
        endcase

        // Core supply loss is ignored until backup reset is released
        if (!core_por_i && s_r.res.backup_rst_n) begin
            s_nxt.st = ST_CORE_OFF;
            s_nxt.cnt = 16'h0000;
            s_nxt.clk_en = 1'b0;
            s_nxt.res.proc_rst_n = 1'b0;
            s_nxt.res.periph_rst_n = 1'b0;
            ext_start = 1'b0;
            ext_force = 1'b1;
        end

        if (!backup_por_i) begin
            s_nxt.st = ST_STARTUP;
            s_nxt.cnt = 16'h0000;
            s_nxt.clk_en = 1'b0;
            s_nxt.res = '{default: 1'b0};
            s_nxt.mode = MODE_RST;
            ext_start = 1'b0;
            ext_force = 1'b1;
        end
    end

    // Async reset stands for backup supply loss
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_r <= S_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    src_ext_pulse u_pulse (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .force_i    (ext_force),
        .start_i    (ext_start),
        .len_i      (s_r.mode.ext_pulse_length),
        .drive_o    (ext_pin_oe_o)
    );

    assign ext_pin_o     = 1'b0;
    assign rdata_o       = s_r.rdata;
    assign resets_o      = s_r.res;
    assign proc_clk_en_o = s_r.clk_en;
    assign boot_sel_o    = s_r.boot_sel;
    assign user_irq_o    = s_r.irq;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_hold_entry;
        s_r.st != ST_HOLD ##1 s_r.st == ST_HOLD;
    endsequence

    sequence s_supplies3;
        (backup_por_i && core_por_i)[*3];
    endsequence

    a_user_entry: assert property (
        user_trig && !wdt_fault_i && !ctrl_ok && backup_por_i && core_por_i
        |=> s_r.st == ST_USER && !resets_o.proc_rst_n)
        else $error("Low pin did not enter user reset");

    a_user_disabled: assert property (
        s_r.st == ST_RUN && !s_r.mode.user_reset_enable |=> s_r.st != ST_USER)
        else $error("User reset entered while disabled");

    a_level_read: assert property (
        stat_rd |=> rdata_o[STAT_LEVEL_BIT] == $past(s_r.pin_sync[1]))
        else $error("Status level bit wrong");

    a_seen_set: assert property (
        pin_fall |=> s_r.user_reset_seen)
        else $error("Seen bit not set on pin fall");

    a_seen_sticky: assert property (
        s_r.user_reset_seen && !stat_rd |=> s_r.user_reset_seen)
        else $error("Seen bit cleared without read");

    a_irq_gate: assert property (
        s_r.user_reset_seen && s_r.mode.user_reset_irq_enable && !stat_rd
        |=> user_irq_o ##0 s_r.st != ST_USER)
        else $error("Interrupt missing or reset taken");

    a_boot_sample: assert property (
        $rose(core_por_i) ##3 1'b1 |=> boot_sel_o == $past(boot_select_pin_i))
        else $error("Boot select not captured three cycles after rise");

    a_type_release: assert property (
        $changed(s_r.last_reset_type) |-> $rose(resets_o.proc_rst_n))
        else $error("Reset type changed outside processor release");

    a_hold_three: assert property (
        s_hold_entry ##0 s_supplies3
        |=> resets_o.proc_rst_n && $past(proc_clk_en_o)
            && !$past(resets_o.proc_rst_n, 3))
        else $error("Startup hold is not three cycles");

    a_general_ext: assert property (
        $rose(resets_o.backup_rst_n) && s_r.mode.ext_pulse_length == 4'h0
        && !$past(bus_i.wr)
        ##0 (!wdt_fault_i && !bus_i.wr && backup_por_i && core_por_i)[*2]
        |=> !ext_pin_oe_o && $past(ext_pin_oe_o) && $past(ext_pin_oe_o, 2))
        else $error("Pin not released two cycles after backup release");

    a_backup_loss: assert property (
        !backup_por_i |=> resets_o == 3'h0 && ext_pin_oe_o)
        else $error("Backup loss did not assert all resets");

    a_sw_three: assert property (
        ctrl_ok && bus_i.wdata[CTRL_PROC_BIT] && !wdt_fault_i
        && backup_por_i && core_por_i
        // A fault in any held cycle preempts the software reset
        ##1 (!wdt_fault_i && backup_por_i && core_por_i)[*3]
        |=> resets_o.proc_rst_n && !$past(resets_o.proc_rst_n, 3))
        else $error("Software reset is not three cycles");

    a_core_gated: assert property (
        !resets_o.backup_rst_n && backup_por_i |=> s_r.st != ST_CORE_OFF)
        else $error("Core supply reset before backup release");

    a_wdt_entry: assert property (
        wdt_fault_i && backup_por_i && core_por_i
        && (s_r.st == ST_RUN || s_r.st == ST_SW)
        |=> s_r.st == ST_WDT && !resets_o.proc_rst_n)
        else $error("Watchdog fault did not preempt");

    a_user_type: assert property (
        s_r.st == ST_HOLD && s_r.pend == RT_USER && s_r.cnt == 16'h0000
        && backup_por_i && core_por_i
        |=> resets_o.proc_rst_n && s_r.last_reset_type == RT_USER)
        else $error("User reset release type wrong");

endmodule : src_core

// ### sim/src_pin_partner.sv
/*
 * Far-side party on the open-drain reset wire: an optional pull-low.
 * Assumes the bench commands pull_i; the board pull-up is modelled here.
 */
`timescale 1ns/1ns
module src_pin_partner (
    input  wire logic dut_oe_i,
    input  wire logic pull_i,
    output logic      pin_o
);
    // Any party pulls low, otherwise the pull-up wins
    assign pin_o = ~(dut_oe_i | pull_i);
endmodule : src_pin_partner

// ### sim/system_reset_controller_tb.sv
/*
 * Self-checking bench for src_core: supply sequencing, pin handling,
 * software, watchdog and wake-up resets, boot select capture.
 * Assumes src_pin_partner resolves the reset wire.
 */
`timescale 1ns/1ns
module system_reset_controller_tb;
    import src_pkg::*;
    logic         core_clk_i = 1'b0;
    logic         reset_i    = 1'b1;
    src_bus_req_t bus        = '0;
    logic         bpor       = 1'b1;
    logic         cpor       = 1'b1;
    logic         wdt        = 1'b0;
    logic         boot       = 1'b0;
    logic         pull       = 1'b0;
    logic [31:0]  rdata;
    src_resets_t  rst;
    logic         pin, pin_do, oe, clk_en, boot_sel, irq;
    int           n_mismatch = 0;
    int           n_tests    = 0;
    int           cyc        = 0;

    src_core u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .bus_i(bus),
        .rdata_o(rdata), .backup_por_i(bpor), .core_por_i(cpor), .ext_pin_i(pin),
        .wdt_fault_i(wdt), .wdt_proc_only_i(1'b0), .boot_select_pin_i(boot),
        .resets_o(rst), .ext_pin_o(pin_do), .ext_pin_oe_o(oe),
        .proc_clk_en_o(clk_en), .boot_sel_o(boot_sel), .user_irq_o(irq));
    src_pin_partner u_pin (.dut_oe_i(oe), .pull_i(pull), .pin_o(pin));

    initial begin
        forever #20 core_clk_i = ~core_clk_i;
    end

    task automatic report_and_stop;
        $display("mismatches=%0d comparisons=%0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk_i) bus <= '0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk_i) bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge core_clk_i) bus <= '0;
        #1 d = rdata;
    endtask : rd

    task automatic wait_proc(input int lim, output int n);
        for (n = 0; n < lim && rst.proc_rst_n !== 1'b1; n++)
            tick(1);
    endtask : wait_proc

    task automatic t_general;
        logic [31:0] d;
        int          i;
        for (i = 0; i < 2100 && rst.backup_rst_n !== 1'b1; i++)
            tick(1);
        chk(i, 32'(STARTUP_LAST) + 32'(HOLD_LAST) + 32'h2);
        chk({rst, clk_en, oe}, 5'h1f);
        tick(1);
        chk(oe, 1'b1);
        tick(1);
        chk({oe, pin_do}, 2'b00);
        // Released pin needs two more edges through the synchroniser
        tick(2);
        rd(OFF_STAT, d);
        chk({d[16], d[10:8]}, {1'b1, RT_GENERAL});
        rd(OFF_MODE, d);
        chk(d, 32'h1);
    endtask : t_general

    task automatic t_soft;
        logic [31:0] d;
        int          n;
        wr(OFF_CTRL, 32'h5a000001);
        chk(rst.proc_rst_n, 1'b0);
        wait_proc(10, n);
        chk(n, 3);
        rd(OFF_STAT, d);
        chk({d[1], d[10:8]}, {1'b0, RT_SW});
    endtask : t_soft

    task automatic t_user;
        logic [31:0] d;
        int          n;
        @(posedge core_clk_i) pull <= 1'b1;
        tick(6);
        chk({rst.proc_rst_n, rst.periph_rst_n}, 2'b00);
        @(posedge core_clk_i) pull <= 1'b0;
        tick(0);
        wait_proc(20, n);
        chk(n, 6);
        rd(OFF_STAT, d);
        chk({d[0], d[10:8]}, {1'b1, RT_USER});
        rd(OFF_STAT, d);
        chk(d[0], 1'b0);
    endtask : t_user

    task automatic t_noreset(input logic [31:0] mode);
        logic [31:0] d;
        wr(OFF_MODE, mode);
        @(posedge core_clk_i) pull <= 1'b1;
        tick(5);
        chk({rst.proc_rst_n, irq}, {1'b1, mode[4]});
        rd(OFF_STAT, d);
        chk({d[16], d[0]}, 2'b01);
        @(posedge core_clk_i) pull <= 1'b0;
        tick(3);
        chk({rst.proc_rst_n, irq}, 2'b10);
    endtask : t_noreset

    task automatic t_pulse(input logic [3:0] len);
        int n = 0;
        wr(OFF_MODE, {20'h0, len, 8'h01});
        wr(OFF_CTRL, 32'h5a000008);
        repeat (40) begin
            n += oe;
            tick(1);
        end
        chk(n, 2 << len);
    endtask : t_pulse

    task automatic t_wdt;
        logic [31:0] d;
        int          n;
        wr(OFF_CTRL, 32'h5a000001);
        @(posedge core_clk_i) wdt <= 1'b1;
        @(posedge core_clk_i) wdt <= 1'b0;
        #1 chk(rst.proc_rst_n, 1'b0);
        wait_proc(40, n);
        rd(OFF_STAT, d);
        chk(d[10:8], RT_WDT);
    endtask : t_wdt

    task automatic t_wake;
        logic [31:0] d;
        int          n;
        wr(OFF_MODE, 32'h101);
        @(posedge core_clk_i) cpor <= 1'b0;
        tick(3);
        chk({rst, clk_en}, 4'b0010);
        @(posedge core_clk_i) cpor <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        boot <= 1'b1;
        @(posedge core_clk_i) boot <= 1'b0;
        #1 chk(boot_sel, 1'b1);
        wait_proc(20, n);
        rd(OFF_STAT, d);
        chk(d[10:8], RT_WAKE);
        rd(OFF_MODE, d);
        chk(d, 32'h101);
    endtask : t_wake

    task automatic t_backup;
        logic [31:0] d;
        @(posedge core_clk_i) bpor <= 1'b0;
        tick(2);
        chk({rst, oe}, 4'b0001);
        @(posedge core_clk_i) bpor <= 1'b1;
        rd(OFF_MODE, d);
        chk(d, 32'h1);
    endtask : t_backup

    // Hang guard well above two startup counts
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 12000) begin
            n_mismatch++;
            report_and_stop;
        end
    end

    initial begin
        repeat (16) @(posedge core_clk_i);
        reset_i <= 1'b0;
        t_general;
        t_soft;
        t_user;
        t_noreset(32'h0);
        t_noreset(32'h11);
        t_pulse(4'h0);
        t_pulse(4'h3);
        t_wdt;
        t_wake;
        t_backup;
        report_and_stop;
    end
endmodule : system_reset_controller_tb
